// *** dv/host_model.sv ***
// apb host model standing in for the host processor on the register bus
// assumes one clock shared with the slave and a slave that raises pready
`timescale 1ns/100ps
module host_model (
	// clock
	input  wire logic        clk,
	// apb request
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	// apb answer
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// ----------------------------------------------------------------
	// bus idle at time zero
	// ----------------------------------------------------------------
	initial begin
		psel    <= 1'b0;
		penable <= 1'b0;
		pwrite  <= 1'b0;
		paddr   <= 12'h000;
		pwdata  <= 32'h0000_0000;
	end

	// ----------------------------------------------------------------
	// one transfer: setup, access until pready, then release
	// ----------------------------------------------------------------
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err, output logic tmo);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		// pready read right after an edge is the value the slave showed at it
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		tmo = (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		paddr   <= ~a;                 // released lines stop showing the old value
		pwdata  <= ~wd;
	endtask : xfer
endmodule : host_model

// *** dv/tb_top.sv ***
// self-checking bench for the reset controller, register access over apb
// assumes the host model for bus cycles and a 50 MHz reference clock
`timescale 1ns/100ps
module tb_top;
	// ----------------------------------------------------------------
	// signals
	// ----------------------------------------------------------------
	logic        ref_clk = 1'b0;
	logic        rst_n   = 1'b0;
	logic        psel, penable, pwrite, pready, pslverr, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  status_a_in = 8'h00;
	logic [7:0]  status_b_in = 8'h00;
	logic [2:0]  tx_load     = 3'h0;
	logic [2:0]  tx_free     = 3'h0;
	logic        section_rst, tx_rst, base_tick, saw;
	logic [7:0]  mode_out, command_out, ctrl6_out, ctrl7_out, dial_out;
	logic [31:0] d;
	logic        e;
	int          n;
	int          err_count = 0;
	int          cmp_count = 0;

	// free-running reference clock
	always #10 ref_clk = ~ref_clk;

	// ----------------------------------------------------------------
	// design and host
	// ----------------------------------------------------------------
	viewdata_peripheral_reset_ctrl #(.ADDR_W(12)) dut_u (
		.REF_CLK(ref_clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .STATUS_A_IN(status_a_in),
		.STATUS_B_IN(status_b_in), .TX_LOAD(tx_load), .TX_FREE(tx_free),
		.SECTION_RST(section_rst), .TX_RST(tx_rst), .BASE_TICK(base_tick),
		.MODE_OUT(mode_out), .COMMAND_OUT(command_out), .CTRL6_OUT(ctrl6_out),
		.CTRL7_OUT(ctrl7_out), .DIAL_OUT(dial_out));
	host_model host_u (
		.clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict();
		$display("compares %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	function automatic logic [11:0] ba(input logic [3:0] idx);
		return {6'h00, idx, 2'b00};
	endfunction : ba

	// bus access, a hung slave counts as a mismatch
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		logic t;
		host_u.xfer(w, a, wd, rd, err, t);
		check(32'(t), 32'h0);
	endtask : acc

	task automatic wr(input logic [3:0] idx, input logic [7:0] v);
		logic [31:0] rd;
		logic        err;
		acc(1'b1, ba(idx), {24'h0, v}, rd, err);
	endtask : wr

	task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp);
		logic [31:0] rd;
		logic        err;
		acc(1'b0, ba(idx), 32'h0, rd, err);
		check(rd, {24'h0, exp});
		check(32'(err), 32'h0);
	endtask : rdchk

	// wait for the reset sequence to finish, noting the transmitter phase
	task automatic wait_done(output logic tx_seen);
		int k;
		tx_seen = 1'b0;
		k = 0;
		do begin
			@(negedge ref_clk);
			k++;
			if (tx_rst === 1'b1)
				tx_seen = 1'b1;
		end while (command_out[5] !== 1'b0 && k < 3000);
		check(32'(k < 3000), 32'h1);
	endtask : wait_done

	// registers 0-3 and 6-8 after any reset: zero except ready flags
	task automatic reset_state();
		logic [3:0] idx [7];
		logic [7:0] exp [7];
		idx = '{vdr_pkg::IDX_STATUS_A, vdr_pkg::IDX_STATUS_B, vdr_pkg::IDX_MODE,
			vdr_pkg::IDX_COMMAND, vdr_pkg::IDX_CTRL_6, vdr_pkg::IDX_CTRL_7, vdr_pkg::IDX_DIAL};
		exp = '{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 7; i++) begin
			rdchk(idx[i], exp[i]);
		end
		check(32'({mode_out, command_out, ctrl6_out, ctrl7_out}), 32'h0);
	endtask : reset_state

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(negedge ref_clk);
		check(32'(section_rst), 32'h1);
		rdchk(vdr_pkg::IDX_COMMAND, 8'h20);
		wait_done(saw);
		check(32'(saw), 32'h1);
		reset_state();
		rdchk(vdr_pkg::IDX_INT_STATUS, 8'h01);
		$display("test power_on done");
		// spacing of two base ticks
		n = 0;
		do begin @(negedge ref_clk); n++; end while (base_tick !== 1'b1 && n < 200);
		n = 0;
		do begin @(negedge ref_clk); n++; end while (base_tick !== 1'b1 && n < 200);
		check(32'(n), 32'(vdr_pkg::BASE_DIV));
		$display("test base_tick done");
		// distinct values per register, status read only, refusals
		wr(vdr_pkg::IDX_MODE, 8'ha5);
		status_a_in <= 8'hf0;
		wr(vdr_pkg::IDX_CTRL_6, 8'h11);
		wr(vdr_pkg::IDX_CTRL_7, 8'h22);
		wr(vdr_pkg::IDX_DIAL, 8'h33);
		wr(vdr_pkg::IDX_STATUS_A, 8'hff);
		rdchk(vdr_pkg::IDX_MODE, 8'ha5);
		rdchk(vdr_pkg::IDX_CTRL_6, 8'h11);
		rdchk(vdr_pkg::IDX_CTRL_7, 8'h22);
		rdchk(vdr_pkg::IDX_DIAL, 8'h33);
		rdchk(vdr_pkg::IDX_STATUS_A, 8'hf1);
		status_a_in <= 8'h00;
		check(32'(mode_out), 32'ha5);
		check(32'({ctrl6_out, ctrl7_out, dial_out}), 32'h0011_2233);
		acc(1'b0, ba(4'h5), 32'h0, d, e);
		check(32'(e), 32'h1);
		acc(1'b1, 12'h048, 32'h0000_00ff, d, e);
		check(32'(e), 32'h1);
		rdchk(vdr_pkg::IDX_MODE, 8'ha5);
		$display("test registers done");
		// interrupt raise, clear, mask
		wr(vdr_pkg::IDX_INT_MASK, 8'h01);
		repeat (2) @(negedge ref_clk);
		check(32'(irq), 32'h1);
		wr(vdr_pkg::IDX_INT_STATUS, 8'h01);
		repeat (2) @(negedge ref_clk);
		check(32'(irq), 32'h0);
		rdchk(vdr_pkg::IDX_INT_STATUS, 8'h00);
		$display("test interrupt done");
		// transmitter events clear and set the ready flags
		tx_load <= 3'b111;
		@(posedge ref_clk);
		tx_load <= 3'b000;
		rdchk(vdr_pkg::IDX_STATUS_A, 8'h00);
		rdchk(vdr_pkg::IDX_STATUS_B, 8'h00);
		tx_free <= 3'b001;
		@(posedge ref_clk);
		tx_free <= 3'b000;
		rdchk(vdr_pkg::IDX_STATUS_A, 8'h01);
		$display("test tx_flags done");
		// soft reset from a dirty state ends like power-on
		wr(vdr_pkg::IDX_COMMAND, 8'h20);
		@(negedge ref_clk);
		check(32'(command_out), 32'h20);
		rdchk(vdr_pkg::IDX_COMMAND, 8'h20);
		wait_done(saw);
		check(32'(saw), 32'h1);
		reset_state();
		rdchk(vdr_pkg::IDX_INT_STATUS, 8'h03);
		check(32'(irq), 32'h1);
		$display("test soft_reset done");
		print_verdict();
	end

	// watchdog against a hung run
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		$display("watchdog expired at %0t", $time);
		print_verdict();
	end
endmodule : tb_top

// *** hdl/reset_sequencer.sv ***
// reset sequencer: sections in reset, then transmitters, then ready
// assumes start is a one-cycle pulse synchronous to clk
`timescale 1ns/100ps
module reset_sequencer #(
	parameter int CNT_W = 10
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// request
	input  wire logic start,
	// phases
	output logic      section_rst,
	output logic      tx_rst,
	output logic      done
);

	vdr_pkg::seq_state_t state;
	vdr_pkg::seq_state_t next_state;
	logic [CNT_W-1:0]    cnt;
	logic [CNT_W-1:0]    next_cnt;
	logic                next_section_rst;
	logic                next_tx_rst;
	logic                next_done;

	// next state and phase counter
	always_comb begin
		next_state = state;
		next_cnt   = CNT_W'(cnt + 1'b1);
		case (state)
			vdr_pkg::ST_SECTIONS: begin
				if (cnt == CNT_W'(vdr_pkg::SECT_RST_CYC - 1)) begin
					next_state = vdr_pkg::ST_TX;
					next_cnt   = '0;
				end
			end
			vdr_pkg::ST_TX: begin
				if (cnt == CNT_W'(vdr_pkg::TX_RST_CYC - 1)) begin
					next_state = vdr_pkg::ST_READY;
					next_cnt   = '0;
				end
			end
			vdr_pkg::ST_READY: begin
				next_cnt = '0;
				if (start) begin
					next_state = vdr_pkg::ST_SECTIONS; // RULE9
				end
			end
			default: begin
				next_state = vdr_pkg::ST_SECTIONS;
				next_cnt   = '0;
			end
		endcase
		next_section_rst = (next_state == vdr_pkg::ST_SECTIONS);
		next_tx_rst      = (next_state == vdr_pkg::ST_TX);
		next_done        = (state == vdr_pkg::ST_TX) && (next_state == vdr_pkg::ST_READY);
	end

	// registers; reset enters the section phase without any host action
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state       <= vdr_pkg::ST_SECTIONS; // RULE2
			cnt         <= '0;
			section_rst <= 1'b1;
			tx_rst      <= 1'b0;
			done        <= 1'b0;
		end else begin
			state       <= next_state;
			cnt         <= next_cnt;
			section_rst <= next_section_rst;
			tx_rst      <= next_tx_rst;
			done        <= next_done;
		end
	end

	// a request while idle runs the same sequence as power-on
	property p_seq_restart;
		@(posedge clk) disable iff (!rst_n)
		(start && state == vdr_pkg::ST_READY) |=> section_rst ##1 section_rst;
	endproperty
	a_seq_restart: assert property (p_seq_restart) else $error("restart did not reset sections"); // RULE9

	// transmitter phase always lasts at least eight cycles and ends with done
	property p_tx_phase;
		@(posedge clk) disable iff (!rst_n)
		$rose(tx_rst) |-> tx_rst [*8];
	endproperty
	a_tx_phase: assert property (p_tx_phase) else $error("transmitter reset phase too short"); // RULE6

endmodule : reset_sequencer

// *** hdl/vdr_pkg.sv ***
// constants, register map and sequencer states for the reset controller
// assumes a 50 MHz reference clock and an apb master with 32-bit data
package vdr_pkg;

	// ----------------------------------------------------------------
	// clock rates and timing
	// ----------------------------------------------------------------
	localparam int REF_CLK_HZ    = 50_000_000;
	localparam int BASE_CLK_HZ   = 1_000_000;                  // internal base rate
	localparam int BASE_DIV      = REF_CLK_HZ / BASE_CLK_HZ;   // ref cycles per base tick
	localparam int CLK_PERIOD_NS = 1_000_000_000 / REF_CLK_HZ;
	localparam int SECT_RST_NS   = 8000;                       // sections held in reset
	localparam int TX_RST_NS     = 2000;                       // transmitters held in reset
	localparam int SECT_RST_CYC  = (SECT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TX_RST_CYC    = (TX_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [3:0] IDX_STATUS_A   = 4'h0;
	localparam logic [3:0] IDX_STATUS_B   = 4'h1;
	localparam logic [3:0] IDX_MODE       = 4'h2;
	localparam logic [3:0] IDX_COMMAND    = 4'h3;
	localparam logic [3:0] IDX_CTRL_6     = 4'h6;
	localparam logic [3:0] IDX_CTRL_7     = 4'h7;
	localparam logic [3:0] IDX_DIAL       = 4'h8;
	localparam logic [3:0] IDX_INT_STATUS = 4'hc;
	localparam logic [3:0] IDX_INT_MASK   = 4'hd;

	// ----------------------------------------------------------------
	// field positions and values after reset
	// ----------------------------------------------------------------
	localparam int         CMD_SWRST_BIT  = 5;
	localparam int         LINE_RDY_BIT   = 0;   // in status a
	localparam int         SB_RDY_BIT     = 0;   // in status b
	localparam int         TAPE_RDY_BIT   = 1;   // in status b
	localparam int         INT_DONE_BIT   = 0;
	localparam int         INT_SWRST_BIT  = 1;
	localparam logic [7:0] REG_RST        = 8'h00;
	localparam logic [1:0] INT_RST        = 2'h0;
	localparam logic [2:0] RDY_RST        = 3'h0;

	// sequencer states
	typedef enum logic [1:0] {ST_SECTIONS, ST_TX, ST_READY} seq_state_t;

endpackage : vdr_pkg

// *** hdl/viewdata_peripheral_reset_ctrl.sv ***
// reset and clock control for a viewdata peripheral, registers on apb
// assumes an apb master on REF_CLK and synchronous section-side inputs
//
// How it works
// RULE1: every internal rate comes from one 1 MHz base tick off REF_CLK; the reset sequencer counts REF_CLK cycles instead.
// RULE2: power-on reset runs the full reset sequence with no host action.
// RULE3: writing one to command bit 5 resets; bit reads one until done.
// RULE4: after reset mode and control registers are zero, viewdata defaults.
// RULE5: registers 0-3 and 6-8 read zero after reset, except ready flags.
// RULE6: after transmitter reset the three transmitter-ready flags become one.
// RULE7: the register is picked by a four-bit register number on the bus.
// RULE8: mode and command are read/write; both status registers read only.
// RULE9: software reset ends in the same state as power-on reset; int_status and int_mask are not cleared by it.
`timescale 1ns/100ps
module viewdata_peripheral_reset_ctrl #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input  wire logic              REF_CLK,
	input  wire logic              RST_N,
	// apb slave
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [ADDR_W-1:0] PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic      [31:0]       PRDATA,
	output logic                   PREADY,
	output logic                   PSLVERR,
	// interrupt
	output logic                   IRQ,
	// section-side status and transmitter events
	input  wire logic [7:0]        STATUS_A_IN,
	input  wire logic [7:0]        STATUS_B_IN,
	input  wire logic [2:0]        TX_LOAD,
	input  wire logic [2:0]        TX_FREE,
	// section-side control
	output logic                   SECTION_RST,
	output logic                   TX_RST,
	output logic                   BASE_TICK,
	output logic      [7:0]        MODE_OUT,
	output logic      [7:0]        COMMAND_OUT,
	output logic      [7:0]        CTRL6_OUT,
	output logic      [7:0]        CTRL7_OUT,
	output logic      [7:0]        DIAL_OUT
);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	localparam int DIV_W = $clog2(vdr_pkg::BASE_DIV);

	logic [7:0]       status_reg_a;
	logic [7:0]       status_reg_b;
	logic [7:0]       mode_reg;
	logic [7:0]       command_reg;
	logic [7:0]       ctrl_reg_6;
	logic [7:0]       ctrl_reg_7;
	logic [7:0]       dial_reg;
	logic [1:0]       int_status;
	logic [1:0]       int_mask;
	logic [2:0]       tx_ready;       // line, serial bus, tape
	logic             sw_start;
	logic             pready;
	logic [31:0]      prdata;
	logic             pslverr;
	logic             irq;
	logic [DIV_W-1:0] div_cnt;
	logic             base_tick;

	logic [7:0]       next_status_reg_a;
	logic [7:0]       next_status_reg_b;
	logic [7:0]       next_mode_reg;
	logic [7:0]       next_command_reg;
	logic [7:0]       next_ctrl_reg_6;
	logic [7:0]       next_ctrl_reg_7;
	logic [7:0]       next_dial_reg;
	logic [1:0]       next_int_status;
	logic [1:0]       next_int_mask;
	logic [2:0]       next_tx_ready;
	logic             next_sw_start;
	logic             next_pready;
	logic [31:0]      next_prdata;
	logic             next_pslverr;
	logic             next_irq;
	logic [DIV_W-1:0] next_div_cnt;
	logic             next_base_tick;

	logic             seq_section_rst;
	logic             seq_tx_rst;
	logic             seq_done;
	logic             seq_active;
	logic [3:0]       idx;
	logic             mapped;
	logic             access;
	logic             wr_acc;
	logic [31:0]      rd_data;

	wire logic line_tx_ready_flag       = tx_ready[0];
	wire logic serial_bus_tx_ready_flag = tx_ready[1];
	wire logic tape_tx_ready_flag       = tx_ready[2];

	// ----------------------------------------------------------------
	// reset sequencer
	// ----------------------------------------------------------------
	reset_sequencer #(
		.CNT_W(10)
	) u_seq (
		.clk        (REF_CLK),
		.rst_n      (RST_N),
		.start      (sw_start),
		.section_rst(seq_section_rst),
		.tx_rst     (seq_tx_rst),
		.done       (seq_done)
	);

	// registers are held clear from the request until the sequence ends
	assign seq_active = seq_section_rst | seq_tx_rst | sw_start;

	// ----------------------------------------------------------------
	// base tick divider
	// ----------------------------------------------------------------
	// one pulse per microsecond; other sections count these ticks
	always_comb begin
		next_div_cnt   = DIV_W'(div_cnt + 1'b1);
		next_base_tick = 1'b0;
		if (div_cnt == DIV_W'(vdr_pkg::BASE_DIV - 1)) begin
			next_div_cnt   = '0; // RULE1
			next_base_tick = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			div_cnt   <= '0;
			base_tick <= 1'b0;
		end else begin
			div_cnt   <= next_div_cnt;
			base_tick <= next_base_tick;
		end
	end

	// ----------------------------------------------------------------
	// apb decode and read mux
	// ----------------------------------------------------------------
	// register number from the low four bits of the word index
	assign idx    = PADDR[5:2]; // RULE7
	assign access = PSEL & PENABLE & ~pready;
	assign wr_acc = PSEL & PENABLE & pready & PWRITE & mapped;

	always_comb begin
		mapped  = (PADDR[ADDR_W-1:6] == '0);
		rd_data = 32'h0000_0000;
		case (idx)
			vdr_pkg::IDX_STATUS_A:   rd_data[7:0] = status_reg_a;
			vdr_pkg::IDX_STATUS_B:   rd_data[7:0] = status_reg_b;
			vdr_pkg::IDX_MODE:       rd_data[7:0] = mode_reg;
			vdr_pkg::IDX_COMMAND:    rd_data[7:0] = command_reg;
			vdr_pkg::IDX_CTRL_6:     rd_data[7:0] = ctrl_reg_6;
			vdr_pkg::IDX_CTRL_7:     rd_data[7:0] = ctrl_reg_7;
			vdr_pkg::IDX_DIAL:       rd_data[7:0] = dial_reg;
			vdr_pkg::IDX_INT_STATUS: rd_data[1:0] = int_status;
			vdr_pkg::IDX_INT_MASK:   rd_data[1:0] = int_mask;
			default:                 mapped       = 1'b0;
		endcase
	end

	// one wait state: pready rises in the second access cycle
	always_comb begin
		next_pready  = access;
		next_prdata  = (access && !PWRITE && mapped) ? rd_data : 32'h0000_0000;
		next_pslverr = access & ~mapped;
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready  <= next_pready;
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// ----------------------------------------------------------------
	// control registers
	// ----------------------------------------------------------------
	// status registers take no writes; reset clears these registers but sets command bit 5
	always_comb begin
		next_mode_reg    = mode_reg;
		next_command_reg = command_reg;
		next_ctrl_reg_6  = ctrl_reg_6;
		next_ctrl_reg_7  = ctrl_reg_7;
		next_dial_reg    = dial_reg;
		next_sw_start    = 1'b0;
		if (seq_active) begin
			next_mode_reg    = vdr_pkg::REG_RST; // RULE4
			next_command_reg = vdr_pkg::REG_RST;
			next_ctrl_reg_6  = vdr_pkg::REG_RST; // RULE5
			next_ctrl_reg_7  = vdr_pkg::REG_RST;
			next_dial_reg    = vdr_pkg::REG_RST;
			next_command_reg[vdr_pkg::CMD_SWRST_BIT] = 1'b1; // RULE3
		end else if (wr_acc) begin
			case (idx)
				vdr_pkg::IDX_MODE:    next_mode_reg   = PWDATA[7:0]; // RULE8
				vdr_pkg::IDX_COMMAND: begin
					next_command_reg = PWDATA[7:0]; // RULE8
					next_sw_start    = PWDATA[vdr_pkg::CMD_SWRST_BIT]; // RULE3
				end
				vdr_pkg::IDX_CTRL_6:  next_ctrl_reg_6 = PWDATA[7:0];
				vdr_pkg::IDX_CTRL_7:  next_ctrl_reg_7 = PWDATA[7:0];
				vdr_pkg::IDX_DIAL:    next_dial_reg   = PWDATA[7:0];
				default:              next_sw_start   = 1'b0;
			endcase
		end
		// the request bit drops once the sequence has finished
		if (seq_done) begin
			next_command_reg[vdr_pkg::CMD_SWRST_BIT] = 1'b0; // RULE3
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			mode_reg    <= vdr_pkg::REG_RST;
			command_reg <= vdr_pkg::REG_RST;
			ctrl_reg_6  <= vdr_pkg::REG_RST;
			ctrl_reg_7  <= vdr_pkg::REG_RST;
			dial_reg    <= vdr_pkg::REG_RST;
			sw_start    <= 1'b0;
		end else begin
			mode_reg    <= next_mode_reg;
			command_reg <= next_command_reg;
			ctrl_reg_6  <= next_ctrl_reg_6;
			ctrl_reg_7  <= next_ctrl_reg_7;
			dial_reg    <= next_dial_reg;
			sw_start    <= next_sw_start;
		end
	end

	// ----------------------------------------------------------------
	// transmitter-ready flags and status registers
	// ----------------------------------------------------------------
	// a load clears a flag, a free sets it; set wins, reset end sets all
	always_comb begin
		next_tx_ready = (tx_ready & ~TX_LOAD) | TX_FREE;
		if (seq_active) begin
			next_tx_ready = vdr_pkg::RDY_RST; // RULE5
		end
		if (seq_done) begin
			next_tx_ready = 3'h7; // RULE6
		end
		next_status_reg_a = seq_active ? vdr_pkg::REG_RST : STATUS_A_IN;
		next_status_reg_b = seq_active ? vdr_pkg::REG_RST : STATUS_B_IN;
		next_status_reg_a[vdr_pkg::LINE_RDY_BIT] = next_tx_ready[0];
		next_status_reg_b[vdr_pkg::SB_RDY_BIT]   = next_tx_ready[1];
		next_status_reg_b[vdr_pkg::TAPE_RDY_BIT] = next_tx_ready[2];
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			tx_ready     <= vdr_pkg::RDY_RST;
			status_reg_a <= vdr_pkg::REG_RST;
			status_reg_b <= vdr_pkg::REG_RST;
		end else begin
			tx_ready     <= next_tx_ready;
			status_reg_a <= next_status_reg_a;
			status_reg_b <= next_status_reg_b;
		end
	end

	// ----------------------------------------------------------------
	// interrupts
	// ----------------------------------------------------------------
	// write one to clear; a new event in the same cycle stays set
	always_comb begin
		next_int_status = int_status;
		next_int_mask   = int_mask;
		if (wr_acc && idx == vdr_pkg::IDX_INT_STATUS) begin
			next_int_status = int_status & ~PWDATA[1:0];
		end
		if (wr_acc && idx == vdr_pkg::IDX_INT_MASK) begin
			next_int_mask = PWDATA[1:0];
		end
		if (seq_done) begin
			next_int_status[vdr_pkg::INT_DONE_BIT] = 1'b1;
		end
		if (sw_start) begin
			next_int_status[vdr_pkg::INT_SWRST_BIT] = 1'b1;
		end
		next_irq = |(next_int_status & next_int_mask);
	end

	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			int_status <= vdr_pkg::INT_RST;
			int_mask   <= vdr_pkg::INT_RST;
			irq        <= 1'b0;
		end else begin
			int_status <= next_int_status;
			int_mask   <= next_int_mask;
			irq        <= next_irq;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign PRDATA      = prdata;
	assign PREADY      = pready;
	assign PSLVERR     = pslverr;
	assign IRQ         = irq;
	assign SECTION_RST = seq_section_rst;
	assign TX_RST      = seq_tx_rst;
	assign BASE_TICK   = base_tick;
	assign MODE_OUT    = mode_reg;
	assign COMMAND_OUT = command_reg;
	assign CTRL6_OUT   = ctrl_reg_6;
	assign CTRL7_OUT   = ctrl_reg_7;
	assign DIAL_OUT    = dial_reg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	localparam int PON_MAX = 520;

	property p_base_tick;
		@(posedge REF_CLK) disable iff (!RST_N)
		base_tick |-> ##50 base_tick;
	endproperty
	a_base_tick: assert property (p_base_tick) else $error("base tick period wrong"); // RULE1

	property p_power_on;
		@(posedge REF_CLK) disable iff (!RST_N)
		$rose(RST_N) |-> ##[1:PON_MAX] seq_done;
	endproperty
	a_power_on: assert property (p_power_on) else $error("power-on sequence did not end"); // RULE2

	property p_swrst_hold;
		@(posedge REF_CLK) disable iff (!RST_N)
		(wr_acc && idx == vdr_pkg::IDX_COMMAND && PWDATA[5] && !seq_active)
			|=> command_reg[5] [*8];
	endproperty
	a_swrst_hold: assert property (p_swrst_hold) else $error("reset bit not held"); // RULE3

	property p_swrst_clear;
		@(posedge REF_CLK) disable iff (!RST_N)
		seq_done |=> !command_reg[5] && command_reg == vdr_pkg::REG_RST;
	endproperty
	a_swrst_clear: assert property (p_swrst_clear) else $error("reset bit not cleared"); // RULE3

	property p_defaults;
		@(posedge REF_CLK) disable iff (!RST_N)
		seq_section_rst |=> mode_reg == 8'h00 && ctrl_reg_6 == 8'h00 && ctrl_reg_7 == 8'h00
			&& dial_reg == 8'h00;
	endproperty
	a_defaults: assert property (p_defaults) else $error("control registers not cleared"); // RULE4

	property p_status_clear;
		@(posedge REF_CLK) disable iff (!RST_N)
		(seq_tx_rst && !seq_done) |=> status_reg_a == 8'h00 && status_reg_b == 8'h00;
	endproperty
	a_status_clear: assert property (p_status_clear) else $error("status not zero in reset"); // RULE5

	property p_ready_set;
		@(posedge REF_CLK) disable iff (!RST_N)
		seq_done |=> line_tx_ready_flag && serial_bus_tx_ready_flag && tape_tx_ready_flag
			##1 status_reg_a[0] && status_reg_b[1:0] == 2'h3;
	endproperty
	a_ready_set: assert property (p_ready_set) else $error("ready flags not set"); // RULE6

	property p_mode_read;
		@(posedge REF_CLK) disable iff (!RST_N)
		(access && !PWRITE && idx == vdr_pkg::IDX_MODE && mapped)
			|=> PREADY && PRDATA == {24'h000000, $past(mode_reg)};
	endproperty
	a_mode_read: assert property (p_mode_read) else $error("mode read wrong"); // RULE7

	property p_mode_write;
		@(posedge REF_CLK) disable iff (!RST_N)
		(wr_acc && idx == vdr_pkg::IDX_MODE && !seq_active) |=> mode_reg == $past(PWDATA[7:0]);
	endproperty
	a_mode_write: assert property (p_mode_write) else $error("mode write lost"); // RULE8

	property p_status_ro;
		@(posedge REF_CLK) disable iff (!RST_N)
		(wr_acc && idx == vdr_pkg::IDX_STATUS_A && !seq_active)
			|=> status_reg_a[7:1] == $past(STATUS_A_IN[7:1]);
	endproperty
	a_status_ro: assert property (p_status_ro) else $error("status took a write"); // RULE8

endmodule : viewdata_peripheral_reset_ctrl
